// *** verilog/abs_map.vh ***
// register offsets, field positions, reset values and timing for the acquisition buffer
// assumes a 25 mhz system clock and a 32-bit classic wishbone register bus
`ifndef ABS_MAP_VH
`define ABS_MAP_VH

// byte offsets
`define ABS_REG_CMD 8'h00
`define ABS_REG_CFG 8'h04
`define ABS_REG_TARGET 8'h08
`define ABS_REG_STATUS 8'h0c
`define ABS_REG_COUNT 8'h10
`define ABS_REG_REPEAT 8'h14
`define ABS_REG_DATA 8'h18
`define ABS_REG_RING_OFS 8'h1c

// command bits (write-only pulses)
`define ABS_CMD_START 0
`define ABS_CMD_STOP 1
`define ABS_CMD_ALL_RST 2
`define ABS_CMD_STAT_RST 3
`define ABS_CMD_MEM_RST 4

// config fields
`define ABS_CFG_RING 0
`define ABS_CFG_COND_LO 1
`define ABS_CFG_COND_HI 2
`define ABS_CFG_REP_LO 8
`define ABS_CFG_REP_HI 15

// start conditions
`define ABS_COND_SW 2'h0
`define ABS_COND_EXT 2'h1
`define ABS_COND_LEVEL 2'h2

// status bits
`define ABS_ST_BUSY 0
`define ABS_ST_TRIG_WAIT 1
`define ABS_ST_CNT_REACHED 2
`define ABS_ST_OVERFLOW 3
`define ABS_ST_CLK_ERR 4
`define ABS_ST_CONV_TO 5

// memory geometry
`define ABS_AW 6
`define ABS_DEPTH 7'h40
`define ABS_DW 16

// reset values
`define ABS_CFG_RST 32'h0000_0000
`define ABS_TARGET_RST 7'h00

// conversion timeout
`define ABS_CLK_HZ 25000000
`define ABS_TIMEOUT_MS 100
`define ABS_TIMEOUT_CYC (`ABS_CLK_HZ / 1000 * `ABS_TIMEOUT_MS)

`endif

// *** verilog/abs_unit.v ***
// acquisition data memory with fifo/ring formats, status flags, errors and reset commands
// assumes converter, trigger and sampling-clock logic run on clk; host uses classic wishbone
`timescale 1ns/10ps
`include "abs_map.vh"

// Summary of operation
// - runs start on command, stop anytime
// - status and data readable during sampling
// - busy from start until done, error, stop
// - trigger wait set until trigger arrives
// - trigger wait set again each repetition
// - count reached when stored hits preset
// - fifo count reached clears below preset
// - ring count reached sticky until reset
// - overflow when writing into full memory
// - fifo overflow halts, keeps stored data
// - ring overflow overwrites oldest samples
// - flag sampling clock too fast
// - no result for too long sets timeout, stops
// - repeat count and stored count readable
// - fifo reads oldest first, frees space
// - ring reads relative to write position
// - ring count covers up to newest
// - ring reads do not consume data
// - samples straight binary from range minimum
// - all reset returns block to initial
// - status reset clears both errors
// - memory reset zeroes counts and flags
// - host selects fifo or ring format
module abs_unit #(
    parameter TIMEOUT_CYCLES = `ABS_TIMEOUT_CYC
) (
    input wire clk,
    input wire rst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire samp_tick,
    input wire sample_valid,
    input wire [15:0] sample_data,
    input wire start_trig,
    output reg conv_start,
    output reg ev_start,
    output reg ev_count,
    output reg ev_overflow,
    output reg ev_clk_err,
    output reg ev_conv_to,
    output reg ev_end
);

    reg [`ABS_DW-1:0] mem [0:`ABS_DEPTH-1];
    reg [`ABS_AW-1:0] wr_ptr;
    reg [`ABS_AW-1:0] rd_ptr;
    reg [6:0] count;
    reg [6:0] ring_ofs;
    reg cfg_ring;
    reg [1:0] cfg_cond;
    reg [7:0] cfg_rep_total;
    reg [6:0] cfg_target;
    reg busy;
    reg trig_wait;
    reg cnt_reached;
    reg overflow;
    reg clk_err;
    reg conv_to;
    reg [7:0] rep_cnt;
    reg [6:0] run_cnt;
    reg pending;
    reg [23:0] to_cnt;

    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr = req & wb_we_i & wb_sel_i[0];
    wire rd = req & ~wb_we_i;
    wire cmd_wr = wr & (wb_adr_i == `ABS_REG_CMD);
    wire c_start = cmd_wr & wb_dat_i[`ABS_CMD_START];
    wire c_stop = cmd_wr & wb_dat_i[`ABS_CMD_STOP];
    wire c_all = cmd_wr & wb_dat_i[`ABS_CMD_ALL_RST];
    wire c_stat = cmd_wr & wb_dat_i[`ABS_CMD_STAT_RST];
    wire c_mem = cmd_wr & wb_dat_i[`ABS_CMD_MEM_RST];
    wire data_rd = rd & (wb_adr_i == `ABS_REG_DATA);
    wire full = (count == `ABS_DEPTH);
    wire accept = sample_valid & busy & ~trig_wait;
    wire pop = data_rd & ~cfg_ring & (count != 7'h00);
    wire push = accept & ~(full & ~cfg_ring);
    wire ovf_ev = accept & full;
    wire [`ABS_AW-1:0] ring_idx = wr_ptr - ring_ofs[`ABS_AW-1:0];
    wire clk_err_ev = samp_tick & busy & pending;
    wire to_ev = busy & ~trig_wait & (to_cnt == TIMEOUT_CYCLES - 1);
    wire run_end = push & (cfg_target != 7'h00) & (run_cnt + 7'h01 == cfg_target);
    wire all_done = run_end & ((cfg_cond == `ABS_COND_SW) |
        ((cfg_rep_total != 8'h00) & (rep_cnt + 8'h01 == cfg_rep_total)));

    reg [6:0] next_count;
    reg next_reached;
    reg [31:0] rd_val;

    // stored count after this cycle's push and pop
    always @* begin
        next_count = count;
        if (cfg_ring) begin
            if (push & ~full) begin
                next_count = count + 7'h01;
            end
        end else begin
            next_count = count + {6'h00, push} - {6'h00, pop};
        end
        next_reached = (cfg_target != 7'h00) & (next_count >= cfg_target);
    end

    // read mux
    always @* begin
        rd_val = 32'h0000_0000;
        case (wb_adr_i)
            `ABS_REG_CFG: begin
                rd_val = {16'h0000, cfg_rep_total, 5'h00, cfg_cond, cfg_ring};
            end
            `ABS_REG_TARGET: begin
                rd_val = {25'h0, cfg_target};
            end
            `ABS_REG_STATUS: begin
                rd_val = {26'h0, conv_to, clk_err, overflow, cnt_reached,
                    trig_wait, busy};
            end
            `ABS_REG_COUNT: begin
                rd_val = {25'h0, count};
            end
            `ABS_REG_REPEAT: begin
                rd_val = {24'h0, rep_cnt};
            end
            `ABS_REG_DATA: begin
                if (cfg_ring) begin
                    rd_val = {16'h0000, mem[ring_idx]};
                end else if (count != 7'h00) begin
                    rd_val = {16'h0000, mem[rd_ptr]};
                end
            end
            `ABS_REG_RING_OFS: begin
                rd_val = {25'h0, ring_ofs};
            end
            default: begin
                rd_val = 32'h0000_0000;
            end
        endcase
    end

    // bus answer one cycle after the request
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (rd) begin
                wb_dat_o <= rd_val;
            end
        end
    end

    // sample storage, codes kept as delivered (straight binary)
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= sample_data;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= {`ABS_AW{1'b0}};
            rd_ptr <= {`ABS_AW{1'b0}};
            count <= 7'h00;
            ring_ofs <= 7'h00;
            cfg_ring <= 1'b0;
            cfg_cond <= `ABS_COND_SW;
            cfg_rep_total <= 8'h00;
            cfg_target <= `ABS_TARGET_RST;
            busy <= 1'b0;
            trig_wait <= 1'b0;
            cnt_reached <= 1'b0;
            overflow <= 1'b0;
            clk_err <= 1'b0;
            conv_to <= 1'b0;
            rep_cnt <= 8'h00;
            run_cnt <= 7'h00;
            pending <= 1'b0;
            to_cnt <= 24'h000000;
            conv_start <= 1'b0;
            ev_start <= 1'b0;
            ev_count <= 1'b0;
            ev_overflow <= 1'b0;
            ev_clk_err <= 1'b0;
            ev_conv_to <= 1'b0;
            ev_end <= 1'b0;
        end else if (c_all) begin
            wr_ptr <= {`ABS_AW{1'b0}};
            rd_ptr <= {`ABS_AW{1'b0}};
            count <= 7'h00;
            ring_ofs <= 7'h00;
            cfg_ring <= 1'b0;
            cfg_cond <= `ABS_COND_SW;
            cfg_rep_total <= 8'h00;
            cfg_target <= `ABS_TARGET_RST;
            busy <= 1'b0;
            trig_wait <= 1'b0;
            cnt_reached <= 1'b0;
            overflow <= 1'b0;
            clk_err <= 1'b0;
            conv_to <= 1'b0;
            rep_cnt <= 8'h00;
            run_cnt <= 7'h00;
            pending <= 1'b0;
            to_cnt <= 24'h000000;
            conv_start <= 1'b0;
            ev_start <= 1'b0;
            ev_count <= 1'b0;
            ev_overflow <= 1'b0;
            ev_clk_err <= 1'b0;
            ev_conv_to <= 1'b0;
            ev_end <= 1'b0;
        end else begin
            // configuration, only while idle
            if (wr & ~busy & (wb_adr_i == `ABS_REG_CFG)) begin
                cfg_ring <= wb_dat_i[`ABS_CFG_RING];
                cfg_cond <= wb_dat_i[`ABS_CFG_COND_HI:`ABS_CFG_COND_LO];
                cfg_rep_total <= wb_dat_i[`ABS_CFG_REP_HI:`ABS_CFG_REP_LO];
            end
            if (wr & ~busy & (wb_adr_i == `ABS_REG_TARGET)) begin
                cfg_target <= wb_dat_i[6:0];
            end

            // ring read position: walks from older toward newer, no consumption
            if (wr & (wb_adr_i == `ABS_REG_RING_OFS)) begin
                ring_ofs <= wb_dat_i[6:0];
            end else if (data_rd & cfg_ring & (ring_ofs > 7'h01)) begin
                ring_ofs <= ring_ofs - 7'h01;
            end

            // pointers and count
            if (push) begin
                wr_ptr <= wr_ptr + {{(`ABS_AW-1){1'b0}}, 1'b1};
                if (cfg_ring & full) begin
                    rd_ptr <= rd_ptr + {{(`ABS_AW-1){1'b0}}, 1'b1};
                end
            end
            if (pop) begin
                rd_ptr <= rd_ptr + {{(`ABS_AW-1){1'b0}}, 1'b1};
            end
            count <= next_count;

            // conversion pacing and sampling clock error
            conv_start <= samp_tick & busy & ~pending;
            if (~busy) begin
                pending <= 1'b0;
            end else if (samp_tick & ~pending) begin
                pending <= 1'b1;
            end else if (sample_valid) begin
                pending <= 1'b0;
            end

            // timeout counter runs while busy and not waiting for a trigger, cleared by each result
            if (~busy | trig_wait | sample_valid) begin
                to_cnt <= 24'h000000;
            end else if (~to_ev) begin
                to_cnt <= to_cnt + 24'h000001;
            end

            // run progress and repetitions
            if (run_end) begin
                run_cnt <= 7'h00;
                rep_cnt <= rep_cnt + 8'h01;
                if (~all_done & (cfg_cond != `ABS_COND_SW)) begin
                    trig_wait <= 1'b1;
                end
            end else if (push) begin
                run_cnt <= run_cnt + 7'h01;
            end

            // trigger arrival
            if (trig_wait & start_trig & ~run_end) begin
                trig_wait <= 1'b0;
            end

            // start, stop, errors, completion
            if (c_start & ~busy) begin
                busy <= 1'b1;
                trig_wait <= (cfg_cond != `ABS_COND_SW);
                run_cnt <= 7'h00;
            end else if (c_stop | all_done | clk_err_ev | to_ev |
                    (ovf_ev & ~cfg_ring)) begin
                busy <= 1'b0;
                trig_wait <= 1'b0;
            end

            // count reached
            if (c_mem) begin
                cnt_reached <= 1'b0;
            end else if (cfg_ring) begin
                if (next_reached) begin
                    cnt_reached <= 1'b1;
                end
            end else begin
                cnt_reached <= next_reached;
            end

            // memory reset: counts and flags, a same-cycle overflow still wins
            if (c_mem) begin
                count <= 7'h00;
                rep_cnt <= 8'h00;
                rd_ptr <= wr_ptr;
                ring_ofs <= 7'h00;
                overflow <= 1'b0;
            end
            if (ovf_ev) begin
                overflow <= 1'b1;
            end

            // status reset, a same-cycle error still wins
            if (c_stat) begin
                clk_err <= 1'b0;
                conv_to <= 1'b0;
            end
            if (clk_err_ev) begin
                clk_err <= 1'b1;
            end
            if (to_ev) begin
                conv_to <= 1'b1;
            end

            // event pulses on flag rising, on trigger arrival (start) and on completion of the final run (end)
            ev_start <= trig_wait & start_trig;
            ev_count <= ~cnt_reached & next_reached & ~c_mem;
            ev_overflow <= ovf_ev & ~overflow;
            ev_clk_err <= clk_err_ev & ~clk_err;
            ev_conv_to <= to_ev & ~conv_to;
            ev_end <= all_done & ~c_stop;
        end
    end

endmodule // abs_unit

// *** test/abs_unit_assertions.sv ***
// checker for the acquisition buffer ports
// assumes one clk domain and async active-high rst
`timescale 1ns/10ps
module abs_unit_chk #(
    parameter TIMEOUT_CYCLES = 50
) (
    input wire clk,
    input wire rst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire samp_tick,
    input wire conv_start,
    input wire ev_start,
    input wire ev_overflow,
    input wire ev_end
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    a_ack_in_time: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_conv_cause: assert property (conv_start |-> $past(samp_tick))
        else $error("conversion without tick");
    a_conv_single: assert property (conv_start |=> !conv_start)
        else $error("conversion pulse too long");
    a_start_pulse: assert property (ev_start |=> !ev_start)
        else $error("start event too long");
    a_ovf_pulse: assert property (ev_overflow |=> !ev_overflow)
        else $error("overflow event too long");
    a_end_pulse: assert property (ev_end |=> !ev_end)
        else $error("end event too long");
    a_rst_quiet: assert property ($fell(rst) |-> !wb_ack_o && !conv_start && !ev_end)
        else $error("output active after reset");
endmodule // abs_unit_chk
bind abs_unit abs_unit_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk_u (.clk(clk), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .samp_tick(samp_tick),
    .conv_start(conv_start), .ev_start(ev_start), .ev_overflow(ev_overflow), .ev_end(ev_end));

// *** test/abs_conv_model.sv ***
// converter model: answers conv_start lat+1 cycles after the edge that samples it
// assumes same clk; lat of ff never answers
`timescale 1ns/10ps
module abs_conv_model (
    input wire clk,
    input wire rst,
    input wire conv_start,
    input wire [7:0] lat,
    output reg sample_valid,
    output reg [15:0] sample_data
);
    reg pend;
    reg [7:0] cnt;
    reg [11:0] code;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pend <= 1'b0;
            cnt <= 8'h00;
            code <= 12'h800;
            sample_valid <= 1'b0;
            sample_data <= 16'h0000;
        end else begin
            sample_valid <= 1'b0;
            sample_data <= ~sample_data;
            if (conv_start && lat != 8'hff) begin
                pend <= 1'b1;
                cnt <= lat;
            end else if (pend && cnt == 8'h00) begin
                pend <= 1'b0;
                sample_valid <= 1'b1;
                sample_data <= {4'h0, code};
                code <= code + 12'h001;
            end else if (pend) begin
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule // abs_conv_model

// *** test/tb_top.sv ***
// testbench for the acquisition buffer
// assumes abs_unit and abs_conv_model
`timescale 1ns/10ps
`include "abs_map.vh"
module tb_top;
    reg clk;
    reg rst;
    reg cyc;
    reg stb;
    reg we;
    reg tick;
    reg trig;
    reg [7:0] adr;
    reg [31:0] wd;
    reg [7:0] lat;
    reg [31:0] r;
    reg [11:0] b;
    reg [5:0] evs;
    reg ev_clr;
    wire [31:0] rd;
    wire ack;
    wire sv;
    wire cs;
    wire [15:0] sd;
    wire [5:0] ev;
    integer num_errors;
    integer n_compared;
    integer nsamp;
    abs_unit #(.TIMEOUT_CYCLES(50)) dut_u (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wd),
        .wb_dat_o(rd), .wb_ack_o(ack), .samp_tick(tick), .sample_valid(sv),
        .sample_data(sd), .start_trig(trig), .conv_start(cs), .ev_start(ev[0]),
        .ev_count(ev[1]), .ev_overflow(ev[2]), .ev_clk_err(ev[3]), .ev_conv_to(ev[4]),
        .ev_end(ev[5]));
    abs_conv_model conv_u (.clk(clk), .rst(rst), .conv_start(cs), .lat(lat),
        .sample_valid(sv), .sample_data(sd));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        if (sv === 1'b1) nsamp <= nsamp + 1;
    end
    // sticky record of event pulses since the last run set-up
    always @(posedge clk) begin
        if (ev_clr) evs <= 6'h00;
        else evs <= evs | ev;
    end
    task end_sim;
        begin
            $display("errors %0d compared %0d", num_errors, n_compared);
            if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task wb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= a;
            wd <= d;
            @(posedge clk);
            while (ack !== 1'b1) @(posedge clk);
            r = rd;
            cyc <= 1'b0;
            stb <= 1'b0;
            we <= 1'b0;
        end
    endtask
    task rdc(input [7:0] a, input [31:0] e);
        begin
            wb(1'b0, a, 32'h0);
            chk(r, e);
        end
    endtask
    task cmd(input [4:0] c);
        wb(1'b1, `ABS_REG_CMD, {27'h0, c});
    endtask
    task pulse(input integer which);
        begin
            @(posedge clk);
            if (which == 0) tick <= 1'b1;
            else trig <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
            trig <= 1'b0;
        end
    endtask
    task tk(input integer n);
        integer j;
        integer k;
        for (j = 0; j < n; j = j + 1) begin
            pulse(0);
            k = 0;
            while (sv !== 1'b1 && k < 40) begin
                @(posedge clk);
                k = k + 1;
            end
            @(posedge clk);
        end
    endtask
    task run(input [31:0] cfg, input [31:0] tgt);
        begin
            @(posedge clk);
            ev_clr <= 1'b1;
            @(posedge clk);
            ev_clr <= 1'b0;
            cmd(5'h10);
            wb(1'b1, `ABS_REG_CFG, cfg);
            wb(1'b1, `ABS_REG_TARGET, tgt);
            cmd(5'h01);
            b = 12'h800 + nsamp[11:0];
        end
    endtask
    task t_fifo;
        begin
            run(0, 4);
            rdc(`ABS_REG_STATUS, 32'h1);
            tk(4);
            rdc(`ABS_REG_COUNT, 4);
            rdc(`ABS_REG_STATUS, 32'h4);
            chk({26'h0, evs}, 32'h22);
            rdc(`ABS_REG_DATA, {20'h0, b});
            rdc(`ABS_REG_COUNT, 3);
            rdc(`ABS_REG_STATUS, 0);
            rdc(`ABS_REG_DATA, {20'h0, b + 12'h1});
        end
    endtask
    task t_ring;
        begin
            run(1, 3);
            tk(3);
            rdc(`ABS_REG_COUNT, 3);
            rdc(`ABS_REG_REPEAT, 1);
            chk({26'h0, evs}, 32'h22);
            wb(1'b1, `ABS_REG_RING_OFS, 3);
            rdc(`ABS_REG_DATA, {20'h0, b});
            rdc(`ABS_REG_DATA, {20'h0, b + 12'h1});
            rdc(`ABS_REG_DATA, {20'h0, b + 12'h2});
            rdc(`ABS_REG_DATA, {20'h0, b + 12'h2});
            wb(1'b1, `ABS_REG_RING_OFS, 3);
            rdc(`ABS_REG_DATA, {20'h0, b});
            rdc(`ABS_REG_STATUS, 32'h4);
            cmd(5'h10);
            rdc(`ABS_REG_COUNT, 0);
            rdc(`ABS_REG_STATUS, 0);
            rdc(`ABS_REG_REPEAT, 0);
        end
    endtask
    task t_ovf;
        begin
            run(0, 0);
            tk(65);
            rdc(`ABS_REG_STATUS, 32'h8);
            chk({26'h0, evs}, 32'h04);
            rdc(`ABS_REG_COUNT, 32'h40);
            rdc(`ABS_REG_DATA, {20'h0, b});
            run(1, 0);
            tk(66);
            rdc(`ABS_REG_STATUS, 32'h9);
            chk({26'h0, evs}, 32'h04);
            cmd(5'h02);
            wb(1'b1, `ABS_REG_RING_OFS, 1);
            rdc(`ABS_REG_DATA, {20'h0, b + 12'd65});
            wb(1'b1, `ABS_REG_RING_OFS, 64);
            rdc(`ABS_REG_DATA, {20'h0, b + 12'h2});
        end
    endtask
    task t_trig;
        begin
            run(32'h202, 1);
            rdc(`ABS_REG_STATUS, 32'h3);
            pulse(1);
            rdc(`ABS_REG_STATUS, 32'h1);
            tk(1);
            rdc(`ABS_REG_STATUS, 32'h7);
            pulse(1);
            tk(1);
            rdc(`ABS_REG_STATUS, 32'h4);
            rdc(`ABS_REG_REPEAT, 2);
            chk({26'h0, evs}, 32'h23);
        end
    endtask
    task t_stop;
        begin
            run(0, 0);
            wb(1'b1, `ABS_REG_CFG, 1);
            rdc(`ABS_REG_CFG, 0);
            rdc(`ABS_REG_STATUS, 32'h1);
            cmd(5'h02);
            rdc(`ABS_REG_STATUS, 0);
            chk({26'h0, evs}, 32'h00);
        end
    endtask
    task t_err;
        begin
            lat = 8'd20;
            run(0, 0);
            pulse(0);
            repeat (3) @(posedge clk);
            pulse(0);
            // let the slow conversion finish before the next run starts
            repeat (30) @(posedge clk);
            rdc(`ABS_REG_STATUS, 32'h10);
            chk({26'h0, evs}, 32'h08);
            cmd(5'h08);
            rdc(`ABS_REG_STATUS, 0);
            lat = 8'hff;
            run(0, 0);
            tk(1);
            // wait past the shortened timeout of 50 cycles
            repeat (20) @(posedge clk);
            rdc(`ABS_REG_STATUS, 32'h20);
            chk({26'h0, evs}, 32'h10);
            cmd(5'h08);
            rdc(`ABS_REG_STATUS, 0);
            lat = 8'h02;
        end
    endtask
    task t_all;
        begin
            wb(1'b1, `ABS_REG_CFG, 1);
            wb(1'b1, `ABS_REG_TARGET, 5);
            rdc(`ABS_REG_TARGET, 5);
            cmd(5'h04);
            rdc(`ABS_REG_CFG, 0);
            rdc(`ABS_REG_TARGET, 0);
            wb(1'b1, 8'h20, 32'h5a);
            rdc(8'h20, 0);
        end
    endtask
    initial begin
        #(40 * 20000);
        num_errors = num_errors + 1;
        end_sim;
    end
    initial begin
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        wd = 32'h0;
        tick = 1'b0;
        trig = 1'b0;
        ev_clr = 1'b1;
        lat = 8'h02;
        num_errors = 0;
        n_compared = 0;
        nsamp = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        ev_clr <= 1'b0;
        t_fifo;
        t_ring;
        t_ovf;
        t_trig;
        t_stop;
        t_err;
        t_all;
        end_sim;
    end
endmodule // tb_top
